/* File: logic/lprtc_map.svh */
// lprtc_map.svh: register offsets, field layouts and counter constants
// assumes: a wishbone slave with 32-bit data, byte addresses
`ifndef LPRTC_MAP_SVH
`define LPRTC_MAP_SVH
`define LPRTC_ADR_START 12'h000
`define LPRTC_ADR_STOP 12'h004
`define LPRTC_ADR_CLEAR 12'h008
`define LPRTC_ADR_FORCE 12'h00C
`define LPRTC_ADR_EV_TICK 12'h100
`define LPRTC_ADR_EV_WRAP 12'h104
`define LPRTC_ADR_EV_MATCH 12'h140
`define LPRTC_ADR_ROUTE 12'h340
`define LPRTC_ADR_ROUTE_SET 12'h344
`define LPRTC_ADR_ROUTE_CLR 12'h348
`define LPRTC_ADR_STATUS 12'h400
`define LPRTC_ADR_COUNTER 12'h504
`define LPRTC_ADR_PRESCALE 12'h508
`define LPRTC_ADR_MATCH 12'h540
`define LPRTC_BIT_TICK 0
`define LPRTC_BIT_WRAP 1
`define LPRTC_BIT_MATCH0 16
`define LPRTC_NEAR_WRAP 24'hFFFFF0
`define LPRTC_ALL_ONES 24'hFFFFFF
`define LPRTC_SYNC_MAX 3'h3
`endif

/* File: logic/lprtc_pkg.sv */
// lprtc_pkg.sv: types shared by the counter block
// assumes: included map header supplies the numbers
package lprtc_pkg;
  typedef enum logic [1:0] {
    LPRTC_IDLE = 2'b00,
    LPRTC_WAIT = 2'b01,
    LPRTC_DONE = 2'b10
  } lprtc_rd_t;
endpackage : lprtc_pkg

/* File: logic/lprtc_core.sv */
// lprtc_core.sv: low-power real-time counter with wishbone registers
// assumes: slow_clock_32k is an asynchronous pin, clk_sys is 100 MHz
`timescale 1ns/1ps
`include "lprtc_map.svh"
module lprtc_core #(
  parameter int NUM_MATCH = 4 // number of match registers
) (
  input wire logic clk_sys, // 100 MHz system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic slow_clock_32k, // 32.768 kHz slow clock pin
  input wire logic slow_clock_running, // slow clock already up
  output logic slow_clock_request, // ask for slow clock, RC source
  output logic rc_source_select, // high: request uses RC source
  output logic fast_clock_request, // routed event wants fast clocks
  output logic [NUM_MATCH+1:0] event_pulse, // routed events, one cycle
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [11:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o // wishbone acknowledge
);
  localparam int NEV = NUM_MATCH + 2;

  logic [23:0] counter;
  logic [11:0] prescale;
  logic [11:0] internal_divide_count;
  logic [23:0] match_value [NUM_MATCH];
  logic [NEV-1:0] event_routing_enable;
  logic [NEV-1:0] ev_flag;
  logic running;
  logic [1:0] sync;
  logic slow_q;
  logic [1:0] edge_seen;
  logic pend_clear;
  logic pend_stop;
  logic pend_force;
  logic [23:0] count_copy;
  lprtc_pkg::lprtc_rd_t rd_state;

  // slow clock edges, sync[0] feeds sync[1] only
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sync <= 2'h0;
      slow_q <= 1'b0;
    end else begin
      sync <= {sync[0], slow_clock_32k};
      slow_q <= sync[1];
    end
  end
  wire slow_rise = sync[1] && !slow_q;
  wire slow_fall = !sync[1] && slow_q;

  // bus decode
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd_counter = req && !wb_we_i && wb_adr_i == `LPRTC_ADR_COUNTER;
  wire wr = req && wb_we_i && wb_sel_i[0];
  wire wr_start = wr && wb_adr_i == `LPRTC_ADR_START && wb_dat_i[0];
  wire wr_stop = wr && wb_adr_i == `LPRTC_ADR_STOP && wb_dat_i[0];
  wire wr_clear = wr && wb_adr_i == `LPRTC_ADR_CLEAR && wb_dat_i[0];
  wire wr_force = wr && wb_adr_i == `LPRTC_ADR_FORCE && wb_dat_i[0];

  // delayed tasks need a falling then a rising slow edge
  wire any_pend = pend_clear || pend_stop || pend_force;
  wire pend_fire = any_pend && edge_seen[1] && slow_rise;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      edge_seen <= 2'h0;
    end else if (!any_pend || pend_fire) begin
      edge_seen <= 2'h0;
    end else if (slow_fall) begin
      edge_seen <= 2'h2;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pend_clear <= 1'b0;
      pend_stop <= 1'b0;
      pend_force <= 1'b0;
    end else if (pend_fire) begin
      pend_clear <= wr_clear;
      pend_stop <= wr_stop;
      pend_force <= wr_force;
    end else begin
      pend_clear <= pend_clear || wr_clear;
      pend_stop <= pend_stop || wr_stop;
      pend_force <= pend_force || wr_force;
    end
  end
  wire do_clear = pend_fire && pend_clear;
  wire do_stop = pend_fire && pend_stop;
  wire do_force = pend_fire && pend_force;

  // run state; stop gates events at once
  logic events_on;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      running <= 1'b0;
      events_on <= 1'b0;
    end else if (wr_start) begin
      running <= 1'b1;
      events_on <= 1'b1;
    end else begin
      if (wr_stop) events_on <= 1'b0;
      if (do_stop) running <= 1'b0;
    end
  end

  // clock requests
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      slow_clock_request <= 1'b0;
    end else if (wr_start && !slow_clock_running) begin
      slow_clock_request <= 1'b1;
    end else if (do_stop) begin
      slow_clock_request <= 1'b0;
    end
  end
  assign rc_source_select = slow_clock_request;

  // divider and counter, stepped on slow rising edge
  wire step = running && slow_rise && internal_divide_count == 12'h000;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      internal_divide_count <= 12'h000;
    end else if (wr_start || do_clear || do_force) begin
      internal_divide_count <= prescale;
    end else if (running && slow_rise) begin
      if (internal_divide_count == 12'h000)
        internal_divide_count <= prescale;
      else
        internal_divide_count <= internal_divide_count - 12'h001;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      counter <= 24'h000000;
    end else if (do_clear) begin
      counter <= 24'h000000;
    end else if (do_force) begin
      counter <= `LPRTC_NEAR_WRAP;
    end else if (step) begin
      counter <= counter + 24'h000001;
    end
  end

  // events fire only on a step, never on start or clear
  logic [NEV-1:0] raw_ev;
  always_comb begin
    raw_ev = '0;
    raw_ev[`LPRTC_BIT_TICK] = step;
    raw_ev[`LPRTC_BIT_WRAP] = step && counter == `LPRTC_ALL_ONES;
    for (int i = 0; i < NUM_MATCH; i++)
      raw_ev[i+2] = step && counter + 24'h000001 == match_value[i];
  end
  wire [NEV-1:0] gated_ev = raw_ev & event_routing_enable & {NEV{events_on}};
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      event_pulse <= '0;
      fast_clock_request <= 1'b0;
    end else begin
      event_pulse <= gated_ev;
      fast_clock_request <= |gated_ev;
    end
  end

  // event flags: set wins over a clear
  logic [NEV-1:0] ev_clr;
  always_comb begin
    ev_clr = '0;
    if (wr && !wb_dat_i[0]) begin
      if (wb_adr_i == `LPRTC_ADR_EV_TICK) ev_clr[0] = 1'b1;
      if (wb_adr_i == `LPRTC_ADR_EV_WRAP) ev_clr[1] = 1'b1;
      for (int i = 0; i < NUM_MATCH; i++)
        if (wb_adr_i == `LPRTC_ADR_EV_MATCH + 12'(4 * i)) ev_clr[i+2] = 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) ev_flag <= '0;
    else ev_flag <= (ev_flag & ~ev_clr) | gated_ev;
  end

  // configuration writes
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      event_routing_enable <= '0;
      prescale <= 12'h000;
      for (int i = 0; i < NUM_MATCH; i++) match_value[i] <= 24'h000000;
    end else if (wr) begin
      if (wb_adr_i == `LPRTC_ADR_PRESCALE && !running)
        prescale <= wb_dat_i[11:0];
      for (int i = 0; i < NUM_MATCH; i++)
        if (wb_adr_i == `LPRTC_ADR_MATCH + 12'(4 * i))
          match_value[i] <= wb_dat_i[23:0];
      if (wb_adr_i == `LPRTC_ADR_ROUTE)
        event_routing_enable <= {wb_dat_i[`LPRTC_BIT_MATCH0 +: NUM_MATCH],
          wb_dat_i[1:0]};
      else if (wb_adr_i == `LPRTC_ADR_ROUTE_SET)
        event_routing_enable <= event_routing_enable |
          {wb_dat_i[`LPRTC_BIT_MATCH0 +: NUM_MATCH], wb_dat_i[1:0]};
      else if (wb_adr_i == `LPRTC_ADR_ROUTE_CLR)
        event_routing_enable <= event_routing_enable &
          ~{wb_dat_i[`LPRTC_BIT_MATCH0 +: NUM_MATCH], wb_dat_i[1:0]};
    end
  end

  // counter read: wait for a quiet slow-clock window, then latch copy
  logic [2:0] rd_wait;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rd_state <= lprtc_pkg::LPRTC_IDLE;
      rd_wait <= 3'h0;
      count_copy <= 24'h000000;
    end else begin
      unique case (rd_state)
        lprtc_pkg::LPRTC_IDLE: begin
          rd_wait <= 3'h0;
          if (rd_counter) rd_state <= lprtc_pkg::LPRTC_WAIT;
        end
        lprtc_pkg::LPRTC_WAIT: begin
          rd_wait <= rd_wait + 3'h1;
          if (rd_wait == `LPRTC_SYNC_MAX || !slow_rise) begin
            count_copy <= counter;
            rd_state <= lprtc_pkg::LPRTC_DONE;
          end
        end
        lprtc_pkg::LPRTC_DONE: rd_state <= lprtc_pkg::LPRTC_IDLE;
        default: rd_state <= lprtc_pkg::LPRTC_IDLE;
      endcase
    end
  end

  // ack and read data
  logic [31:0] next_dat;
  always_comb begin
    next_dat = 32'h00000000;
    unique case (wb_adr_i)
      `LPRTC_ADR_EV_TICK: next_dat[0] = ev_flag[0];
      `LPRTC_ADR_EV_WRAP: next_dat[0] = ev_flag[1];
      `LPRTC_ADR_ROUTE, `LPRTC_ADR_ROUTE_SET, `LPRTC_ADR_ROUTE_CLR: begin
        next_dat[1:0] = event_routing_enable[1:0];
        next_dat[`LPRTC_BIT_MATCH0 +: NUM_MATCH] =
          event_routing_enable[NEV-1:2];
      end
      `LPRTC_ADR_STATUS: next_dat[2:0] = {slow_clock_request, any_pend,
        running};
      `LPRTC_ADR_PRESCALE: next_dat[11:0] = prescale;
      default: begin
        for (int i = 0; i < NUM_MATCH; i++) begin
          if (wb_adr_i == `LPRTC_ADR_MATCH + 12'(4 * i))
            next_dat[23:0] = match_value[i];
          if (wb_adr_i == `LPRTC_ADR_EV_MATCH + 12'(4 * i))
            next_dat[0] = ev_flag[i+2];
        end
      end
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (rd_state == lprtc_pkg::LPRTC_DONE) begin
      wb_ack_o <= 1'b1;
      wb_dat_o <= {8'h00, count_copy};
    end else begin
      wb_ack_o <= req && !rd_counter;
      wb_dat_o <= next_dat;
    end
  end

  // read stall is counted from the cycle the request is taken
  a_read_bound: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    rd_counter && rd_state == lprtc_pkg::LPRTC_IDLE |-> ##[2:6] wb_ack_o)
    else $error("counter read not answered within six cycles");
  a_ack_pulse: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");
  a_force_load: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    do_force && !do_clear |=> counter == `LPRTC_NEAR_WRAP)
    else $error("force task did not load near wrap value");
  a_clear_load: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    do_clear |=> counter == 24'h000000)
    else $error("clear task did not zero the counter");
  a_wrap_event: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    raw_ev[`LPRTC_BIT_WRAP] && !do_force |=> counter == 24'h000000)
    else $error("wrap event without counter at zero");
  a_wrap_continue: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    step && counter == 24'h000000 && !do_clear && !do_force
      |=> counter == 24'h000001)
    else $error("counter did not step on from zero");
  a_tick_step: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    step && events_on && event_routing_enable[`LPRTC_BIT_TICK]
      |=> event_pulse[`LPRTC_BIT_TICK])
    else $error("routed tick missing on a step");
  a_match_value: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    event_pulse[2] && !$past(do_clear || do_force)
      |-> counter == $past(match_value[0]))
    else $error("match event with counter off the match value");
  a_stop_blocks: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    wr_stop |=> !events_on ##1 event_pulse == '0)
    else $error("event after stop task");
  a_prescale_hold: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    running && $past(running) |-> $stable(prescale))
    else $error("prescaler changed while running");
  a_routing_gate: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    fast_clock_request |-> $past(|(raw_ev & event_routing_enable)))
    else $error("fast clock requested by unrouted event");
  a_step_reload: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    step && !do_clear && !do_force
      |=> internal_divide_count == $past(prescale))
    else $error("divide count not reloaded on step");
  a_task_delay: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    wr_clear && !any_pend |-> !do_clear [*3])
    else $error("clear acted without slow clock edges");
endmodule : lprtc_core

/* File: dv/lprtc_core_bench.sv */
// lprtc_core_bench.sv: self-checking bench for the low-power rtc counter
// assumes: lprtc_map.svh on the include path, wishbone slave in lprtc_core
`timescale 1ns/1ps
`include "lprtc_map.svh"
module lprtc_core_bench;
  localparam int NM = 4;
  logic clk_sys, resetn, slow_clock_32k, slow_clock_running;
  logic cyc, stb, we, ack, slow_req, rc_sel, fast_req;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, m;
  logic [NM+1:0] ev;
  int fails, num_checks, n, slow_edges, prev_edge, gap;
  int n_tick, n_wrap, n_m0, n_fast, n_mx;
  lprtc_core #(.NUM_MATCH(NM)) DUT (
    .clk_sys(clk_sys), .resetn(resetn), .slow_clock_32k(slow_clock_32k),
    .slow_clock_running(slow_clock_running),
    .slow_clock_request(slow_req), .rc_source_select(rc_sel),
    .fast_clock_request(fast_req), .event_pulse(ev),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  // slow pin sped up to keep the run short; still 20x slower than clk_sys
  initial begin
    slow_clock_32k = 0;
    forever #101 slow_clock_32k = ~slow_clock_32k;
  end
  always @(posedge slow_clock_32k) slow_edges++;
  always @(posedge clk_sys) begin
    if (ev[0] === 1'b1) begin
      gap = slow_edges - prev_edge;
      prev_edge = slow_edges;
      n_tick++;
    end
    if (ev[1] === 1'b1) n_wrap++;
    if (ev[2] === 1'b1) n_m0++;
    if (fast_req === 1'b1) n_fast++;
    if ((|ev[NM+1:3]) === 1'b1) n_mx++;
  end
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // classic cycle; master holds everything until ack is sampled high
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_sys);
    check("ack drop", 0, {31'h0, ack === 1'b1});
  endtask : xfer
  task rd_cnt();
    xfer(1'b0, `LPRTC_ADR_COUNTER, 32'h0);
    check("counter read cycles", 1, {31'h0, n <= 6});
  endtask : rd_cnt
  task wait_ev(input int b);
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (ev[b] !== 1'b1 && k < 3000);
    check("event seen", 1, {31'h0, ev[b] === 1'b1});
    @(posedge clk_sys);
  endtask : wait_ev
  task zero();
    #1;
    n_tick = 0;
    n_wrap = 0;
    n_m0 = 0;
    n_fast = 0;
  endtask : zero
  task final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    #100us;
    fails++;
    $display("MISMATCH watchdog expected done seen hang");
    final_report();
  end
  initial begin
    resetn = 0;
    slow_clock_running = 0;
    {cyc, stb, we, adr, wdat} = '0;
    sel = 4'hF;
    {fails, num_checks, slow_edges, prev_edge, gap, n_mx} = '0;
    zero();
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    xfer(1'b0, `LPRTC_ADR_ROUTE, 32'h0);
    check("routing reset", 32'h0, q);
    rd_cnt();
    check("counter reset", 32'h0, q);
    xfer(1'b0, 12'h7FC, 32'h0);
    check("unmapped read", 32'h0, q);
    $display("test reset done");
    xfer(1'b1, `LPRTC_ADR_PRESCALE, 32'h2);
    xfer(1'b0, `LPRTC_ADR_PRESCALE, 32'h0);
    check("prescaler stopped", 32'h2, q);
    xfer(1'b1, `LPRTC_ADR_ROUTE_SET, 32'h0001_0003);
    xfer(1'b0, `LPRTC_ADR_ROUTE, 32'h0);
    check("routing set", 32'h0001_0003, q);
    xfer(1'b1, `LPRTC_ADR_START, 32'h1);
    repeat (2) @(posedge clk_sys);
    check("slow request", 1, {31'h0, slow_req});
    check("rc source", 1, {31'h0, rc_sel});
    xfer(1'b1, `LPRTC_ADR_PRESCALE, 32'h5);
    xfer(1'b0, `LPRTC_ADR_PRESCALE, 32'h0);
    check("prescaler running", 32'h2, q);
    zero();
    wait_ev(0);
    wait_ev(0);
    check("tick gap", 32'd3, gap);
    check("fast request", 1, {31'h0, n_fast > 0});
    $display("test rate done");
    rd_cnt();
    m = q + 32'd2;
    xfer(1'b1, `LPRTC_ADR_MATCH, m);
    zero();
    wait_ev(2);
    rd_cnt();
    check("match value", m, q);
    $display("test match done");
    xfer(1'b1, `LPRTC_ADR_FORCE, 32'h1);
    repeat (48) @(posedge clk_sys);
    rd_cnt();
    check("forced value", {8'h0, `LPRTC_NEAR_WRAP}, q);
    zero();
    wait_ev(1);
    rd_cnt();
    check("after wrap", 32'h0, q);
    wait_ev(0);
    wait_ev(0);
    rd_cnt();
    check("after wrap count", 32'h2, q);
    check("wrap events", 32'd1, n_wrap);
    check("unrouted matches", 32'd0, n_mx);
    xfer(1'b0, `LPRTC_ADR_EV_WRAP, 32'h0);
    check("wrap flag", 32'h1, q);
    xfer(1'b1, `LPRTC_ADR_EV_WRAP, 32'h0);
    xfer(1'b0, `LPRTC_ADR_EV_WRAP, 32'h0);
    check("wrap flag cleared", 32'h0, q);
    $display("test wrap done");
    xfer(1'b1, `LPRTC_ADR_ROUTE_CLR, 32'hFFFF_FFFF);
    zero();
    repeat (200) @(posedge clk_sys);
    check("unrouted events", 32'd0, n_tick + n_m0 + n_fast);
    rd_cnt();
    check("still counting", 1, {31'h0, q > 32'h2});
    $display("test routing done");
    xfer(1'b1, `LPRTC_ADR_ROUTE_SET, 32'h3);
    xfer(1'b1, `LPRTC_ADR_STOP, 32'h1);
    zero();
    repeat (300) @(posedge clk_sys);
    check("events after stop", 32'd0, n_tick + n_fast);
    rd_cnt();
    m = q;
    repeat (100) @(posedge clk_sys);
    rd_cnt();
    check("stopped counter", m, q);
    check("slow request off", 0, {31'h0, slow_req});
    xfer(1'b0, `LPRTC_ADR_STATUS, 32'h0);
    check("status stopped", 32'h0, q);
    $display("test stop done");
    // start on a counter that already sits on the match value
    xfer(1'b1, `LPRTC_ADR_MATCH, m);
    xfer(1'b1, `LPRTC_ADR_ROUTE, 32'h0001_0000);
    slow_clock_running <= 1'b1;
    zero();
    xfer(1'b1, `LPRTC_ADR_START, 32'h1);
    repeat (40) @(posedge clk_sys);
    check("no match at start", 32'd0, n_m0);
    check("no request running", 0, {31'h0, slow_req});
    // clear while running, so a wrong match event could be seen
    xfer(1'b1, `LPRTC_ADR_MATCH, 32'h0);
    xfer(1'b1, `LPRTC_ADR_CLEAR, 32'h1);
    repeat (60) @(posedge clk_sys);
    rd_cnt();
    check("cleared", 32'h0, q);
    check("no match at zero", 32'd0, n_m0);
    $display("test clear done");
    final_report();
  end
endmodule : lprtc_core_bench
